// file: src/temp_sensor_pkg.sv
// Purpose: Shared constants for the temperature sensor register block
// Assumes: Register index is 3 bits, data port is 16 bits wide
// Notes: 8-bit registers sit in the low byte of the data port
`default_nettype none

package temp_sensor_pkg;

    // Register indices
    localparam logic [2:0] ADDR_CONDITION = 3'h0;
    localparam logic [2:0] ADDR_SETUP = 3'h1;
    localparam logic [2:0] ADDR_TEMP = 3'h2;
    localparam logic [2:0] ADDR_REVISION = 3'h3;
    localparam logic [2:0] ADDR_CRIT = 3'h4;
    localparam logic [2:0] ADDR_HYST = 3'h5;
    localparam logic [2:0] ADDR_HIGH = 3'h6;
    localparam logic [2:0] ADDR_LOW = 3'h7;

    // Power-on values
    localparam logic [7:0] CONDITION_RESET = 8'h80;
    localparam logic [7:0] SETUP_RESET = 8'h00;
    localparam logic [15:0] TEMP_RESET = 16'h0000;
    localparam logic [15:0] CRIT_RESET = 16'h4980;
    localparam logic [7:0] HYST_RESET = 8'h05;
    localparam logic [15:0] HIGH_RESET = 16'h2000;
    localparam logic [15:0] LOW_RESET = 16'h0500;

    // Condition register fields
    localparam int COND_READY_N_BIT = 7;
    localparam int COND_FLAG_LSB = 4;
    localparam logic [3:0] COND_UNUSED = 4'h0;

    // Setup register fields
    localparam int SETUP_RES_BIT = 7;
    localparam int SETUP_MODE_LSB = 5;
    localparam logic [1:0] MODE_ONE_SHOT = 2'h1;
    localparam logic [1:0] MODE_ONE_SPS = 2'h2;

    // Alarm channels, index equals flag position in the 13-bit word
    localparam int CH_LOW = 0;
    localparam int CH_HIGH = 1;
    localparam int CH_CRIT = 2;
    localparam int NUM_CH = 3;

    // Word layout: 13-bit data in [15:3], weight 1/128 degree per bit 0
    localparam logic [15:0] MASK_13BIT = 16'hfff8;
    localparam int HYST_SHIFT = 7;

    typedef enum {CMP_IDLE, CMP_EVAL} cmp_state_t;

endpackage : temp_sensor_pkg

`default_nettype wire

// file: src/limit_check.sv
// Purpose: Signed limit compare with hysteresis for one alarm channel
// Assumes: Value and limit share the 1/128 degree scale, margin in whole degrees
// Notes: Widened by two bits so limit plus or minus margin never wraps
`default_nettype none

module limit_check #(
    parameter int WIDTH = 16
) (
    // Operands
    input wire logic [WIDTH-1:0] value,
    input wire logic [WIDTH-1:0] limit,
    input wire logic [7:0] margin,
    // Direction: high for an under-limit alarm
    input wire logic below,
    // Outcome
    output logic trip,
    output logic recover
);
    import temp_sensor_pkg::*;

    localparam int EW = WIDTH + 2;

    logic signed [EW-1:0] value_ext;
    logic signed [EW-1:0] limit_ext;
    logic signed [EW-1:0] margin_ext;

    assign value_ext = EW'($signed(value));
    assign limit_ext = EW'($signed(limit));
    assign margin_ext = $signed(EW'(margin) << HYST_SHIFT);

    always_comb begin
        if (below) begin
            trip = value_ext < limit_ext;
            recover = value_ext > (limit_ext + margin_ext);
        end else begin
            trip = value_ext > limit_ext;
            recover = value_ext < (limit_ext - margin_ext);
        end
    end

endmodule : limit_check

`default_nettype wire

// file: src/temp_word_format.sv
// Purpose: Shapes raw conversion codes and the readable temperature word
// Assumes: Raw code is a full 16-bit two's complement result
// Notes: Purely combinational; caller registers whatever it keeps
`default_nettype none

module temp_word_format (
    // Mode
    input wire logic res16,
    // Raw result and stored word
    input wire logic [15:0] raw_code,
    input wire logic [15:0] stored,
    input wire logic [2:0] flags,
    // Shaped words
    output logic [15:0] store_word,
    output logic [15:0] view_word,
    output logic [15:0] fixed_q7
);
    import temp_sensor_pkg::*;

    // 13-bit mode keeps sixteenths of a degree only
    assign store_word = res16 ? raw_code : (raw_code & MASK_13BIT);
    // Low bits carry alarm flags unless extended
    assign view_word = res16 ? stored : ((stored & MASK_13BIT) | {13'h0000, flags});
    // Both widths share the 1/128 scale: code/16 in 13-bit equals word/128
    assign fixed_q7 = res16 ? stored : (stored & MASK_13BIT);

endmodule : temp_word_format

`default_nettype wire

// file: src/temp_sensor_regs.sv
// Purpose: Register file, alarm flags and ready flag of the temperature sensor
// Assumes: Conversion results and register accesses come from logic on clk
// Notes: Read data appears one cycle after the read strobe
//
// Functional notes
// - In 13-bit mode one result step equals one sixteenth degree.
// - After each conversion compare stored result against critical, high and low limits.
// - Temperature and limit words default to 13-bit two's complement, sign in MSB.
// - After power-up the three lowest temperature bits are alarm flags.
// - Setup bit 7 set makes the word full 16-bit temperature data.
// - Power-on default is 13-bit temperature width.
// - 13-bit code decodes as code/16, or (code-8192)/16 when negative.
// - 16-bit code decodes as code/128, or (code-65536)/128 when negative.
// - Condition, temperature and revision registers ignore host writes.
// - Alarm flags clear on condition read or return inside limit with hysteresis.
// - Ready bit 7 goes low on new result, high on temperature read.
// - In one-shot and 1 SPS modes a setup write also sets ready high.
// - Bit 4 sets below low limit, clears on read or above low plus margin.
// - Bit 5 sets above high limit, clears on read or below high minus margin.
// - Bit 6 sets above critical limit, clears on read or below critical minus margin.
// - In 13-bit mode word bits 2, 1, 0 carry critical, high, low flags.
`default_nettype none

module temp_sensor_regs
    import temp_sensor_pkg::*;
#(
    // Identity fields, values arbitrary
    parameter logic [4:0] MAKER_CODE = 5'h0a,
    parameter logic [2:0] REVISION_CODE = 3'h3
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Conversion results from the converter
    input wire logic conv_valid,
    input wire logic [15:0] conv_code,
    // Register access
    input wire logic [2:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    output logic reg_rvalid,
    // State for the rest of the device
    output logic [7:0] setup_word,
    output logic [NUM_CH-1:0] alarm_state,
    output logic [15:0] temp_q7,
    output logic result_ready_n
);
    import temp_sensor_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Storage

    logic [15:0] temp_word;
    logic [15:0] crit_limit;
    logic [15:0] high_limit;
    logic [15:0] lower_limit;
    logic [7:0] hysteresis_margin;
    logic [NUM_CH-1:0] cond_flag;
    cmp_state_t cmp_state;

    logic res16;
    logic wr_setup;
    logic rd_condition;
    logic rd_temp;
    logic [1:0] next_mode;
    logic [15:0] store_word;
    logic [15:0] view_word;
    logic [15:0] fixed_word;
    logic [15:0] cmp_value;
    logic [15:0] cmp_limit [NUM_CH];
    logic [NUM_CH-1:0] trip;
    logic [NUM_CH-1:0] recover;
    logic eval;
    logic mode_wr;
    logic [7:0] cond_view;

    assign res16 = setup_word[SETUP_RES_BIT];
    assign wr_setup = reg_wr && (reg_addr == ADDR_SETUP);
    assign rd_condition = reg_rd && (reg_addr == ADDR_CONDITION);
    assign rd_temp = reg_rd && (reg_addr == ADDR_TEMP);
    assign next_mode = reg_wdata[SETUP_MODE_LSB +: 2];
    assign eval = (cmp_state == CMP_EVAL);

    ////////////////////////////////////////////////////////////////////////////
    // Derived controls

    // Continuous and shutdown writes leave the ready flag alone
    assign mode_wr = wr_setup && ((next_mode == MODE_ONE_SHOT) || (next_mode == MODE_ONE_SPS));
    // Condition view; low nibble is hard-wired zero
    assign cond_view = {result_ready_n, cond_flag[CH_CRIT], cond_flag[CH_HIGH], cond_flag[CH_LOW],
                        COND_UNUSED};

    ////////////////////////////////////////////////////////////////////////////
    // Word shaping

    temp_word_format u_format (
        .res16(res16),
        .raw_code(conv_code),
        .stored(temp_word),
        .flags(alarm_state),
        .store_word(store_word),
        .view_word(view_word),
        .fixed_q7(fixed_word)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Writable registers; other indices ignore writes

    // Power-on width is 13-bit since the setup reset clears bit 7
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            setup_word <= SETUP_RESET;
        end else if (wr_setup) begin
            setup_word <= reg_wdata[7:0];
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            crit_limit <= CRIT_RESET;
            high_limit <= HIGH_RESET;
            lower_limit <= LOW_RESET;
            hysteresis_margin <= HYST_RESET;
        end else if (reg_wr) begin
            unique case (reg_addr)
                ADDR_CRIT: begin
                    crit_limit <= reg_wdata;
                end
                ADDR_HIGH: begin
                    high_limit <= reg_wdata;
                end
                ADDR_LOW: begin
                    lower_limit <= reg_wdata;
                end
                ADDR_HYST: begin
                    // Upper byte of the write is dropped on purpose
                    hysteresis_margin <= reg_wdata[7:0];
                end
                default: begin
                    // Condition, setup, temperature and revision untouched here
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Temperature result

    // Only the converter loads this; host writes never reach it
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            temp_word <= TEMP_RESET;
        end else if (conv_valid) begin
            temp_word <= store_word;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            temp_q7 <= TEMP_RESET;
        end else begin
            temp_q7 <= fixed_word;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Compare sequencing: compare the stored word the cycle after it lands

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cmp_state <= CMP_IDLE;
        end else begin
            unique case (cmp_state)
                CMP_IDLE: begin
                    if (conv_valid) begin
                        cmp_state <= CMP_EVAL;
                    end
                end
                CMP_EVAL: begin
                    cmp_state <= conv_valid ? CMP_EVAL : CMP_IDLE;
                end
            endcase
        end
    end

    // Limits lose their low bits in 13-bit mode, like the value
    assign cmp_value = res16 ? temp_word : (temp_word & MASK_13BIT);
    assign cmp_limit[CH_LOW] = res16 ? lower_limit : (lower_limit & MASK_13BIT);
    assign cmp_limit[CH_HIGH] = res16 ? high_limit : (high_limit & MASK_13BIT);
    assign cmp_limit[CH_CRIT] = res16 ? crit_limit : (crit_limit & MASK_13BIT);

    ////////////////////////////////////////////////////////////////////////////
    // Alarm channels

    // One compare per channel, all fed the same masked value
    genvar ch;
    generate
        for (ch = 0; ch < NUM_CH; ch++) begin : g_alarm
            limit_check #(
                .WIDTH(16)
            ) u_check (
                .value(cmp_value),
                .limit(cmp_limit[ch]),
                .margin(hysteresis_margin),
                .below(ch == CH_LOW),
                .trip(trip[ch]),
                .recover(recover[ch])
            );

            // Outcome held with hysteresis; a read does not clear it
            always_ff @(posedge clk or posedge sys_rst) begin
                if (sys_rst) begin
                    alarm_state[ch] <= 1'b0;
                end else if (eval && trip[ch]) begin
                    alarm_state[ch] <= 1'b1;
                end else if (eval && recover[ch]) begin
                    alarm_state[ch] <= 1'b0;
                end
            end

            // Sticky flag; a new trip beats a same-cycle read clear
            always_ff @(posedge clk or posedge sys_rst) begin
                if (sys_rst) begin
                    cond_flag[ch] <= 1'b0;
                end else if (eval && trip[ch]) begin
                    cond_flag[ch] <= 1'b1;
                end else if (rd_condition || (eval && recover[ch])) begin
                    cond_flag[ch] <= 1'b0;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Ready flag, active low

    // Written mode value decides whether a setup write counts
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            result_ready_n <= CONDITION_RESET[COND_READY_N_BIT];
        end else if (conv_valid) begin
            result_ready_n <= 1'b0;
        end else if (rd_temp) begin
            result_ready_n <= 1'b1;
        end else if (mode_wr) begin
            result_ready_n <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read port

    // Data is captured before any read side effect lands
    // No default: all eight indices are mapped
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            unique case (reg_addr)
                ADDR_CONDITION: begin
                    reg_rdata <= {8'h00, cond_view};
                end
                ADDR_SETUP: begin
                    reg_rdata <= {8'h00, setup_word};
                end
                ADDR_TEMP: begin
                    reg_rdata <= view_word;
                end
                ADDR_REVISION: begin
                    reg_rdata <= {8'h00, MAKER_CODE, REVISION_CODE};
                end
                ADDR_CRIT: begin
                    reg_rdata <= crit_limit;
                end
                ADDR_HYST: begin
                    reg_rdata <= {8'h00, hysteresis_margin};
                end
                ADDR_HIGH: begin
                    reg_rdata <= high_limit;
                end
                ADDR_LOW: begin
                    reg_rdata <= lower_limit;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            // Answer pulse lines up with the data capture
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
        end
    end

endmodule : temp_sensor_regs

`default_nettype wire

// file: testbench/temp_sensor_regs_properties.sv
// Purpose: Port checker for temp_sensor_regs
// Assumes: One clock, async active-high reset
// Notes: Limits are not visible here, so alarm changes are tied to conversions only
`default_nettype none

module temp_sensor_regs_check
    import temp_sensor_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Stimulus
    input wire logic conv_valid,
    input wire logic [15:0] conv_code,
    input wire logic [2:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_rd,
    // Responses
    input wire logic [15:0] reg_rdata,
    input wire logic reg_rvalid,
    input wire logic [7:0] setup_word,
    input wire logic [NUM_CH-1:0] alarm_state,
    input wire logic [15:0] temp_q7,
    input wire logic result_ready_n
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    logic setup_wr;
    assign setup_wr = reg_wr && reg_addr == ADDR_SETUP;
    // Mode is taken at the strobe, so a later setup write must not matter
    property p_word(logic res);
        logic [15:0] c;
        (conv_valid && setup_word[SETUP_RES_BIT] == res, c = conv_code)
            |=> ##1 temp_q7 == (res ? c : (c & MASK_13BIT));
    endproperty
    a_read_answer: assert property (reg_rd |=> reg_rvalid) else $error("read not answered");
    a_ready_conv: assert property (conv_valid |=> !result_ready_n) else $error("ready stays high");
    a_ready_read: assert property (reg_rd && reg_addr == ADDR_TEMP && !conv_valid |=> result_ready_n)
        else $error("ready not reset by read");
    a_ready_mode_wr: assert property (setup_wr && !conv_valid && (reg_wdata[6:5] == MODE_ONE_SHOT ||
        reg_wdata[6:5] == MODE_ONE_SPS) |=> result_ready_n) else $error("ready not reset by mode write");
    a_ready_fall_cause: assert property ($fell(result_ready_n) |-> $past(conv_valid))
        else $error("ready fell without result");
    a_cond_unused: assert property (reg_rvalid && $past(reg_addr) == ADDR_CONDITION |->
        reg_rdata[3:0] == COND_UNUSED && reg_rdata[15:8] == 8'h00) else $error("unused bits set");
    a_word_short: assert property (p_word(1'b0)) else $error("13-bit word wrong");
    a_word_long: assert property (p_word(1'b1)) else $error("16-bit word wrong");
    a_flag_embed: assert property (reg_rvalid && $past(reg_addr) == ADDR_TEMP &&
        !$past(setup_word[SETUP_RES_BIT]) |-> reg_rdata[2:0] == $past(alarm_state)) else $error("flags wrong");
    a_alarm_cause: assert property (alarm_state != $past(alarm_state) |-> $past(conv_valid, 2))
        else $error("alarm moved without result");
    c_trip: cover property (conv_valid ##2 alarm_state != 3'h0);
    c_temp_read: cover property (reg_rd && reg_addr == ADDR_TEMP);
    c_sps_write: cover property (setup_wr && reg_wdata[6:5] == MODE_ONE_SPS);
endmodule : temp_sensor_regs_check

bind temp_sensor_regs temp_sensor_regs_check temp_sensor_regs_check_i (.clk, .sys_rst, .conv_valid,
    .conv_code, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata, .reg_rvalid, .setup_word,
    .alarm_state, .temp_q7, .result_ready_n);

`default_nettype wire

// file: testbench/sensor_host_model.sv
// Purpose: Host side of the register port, register reads and writes as tasks
// Assumes: Strobes are one cycle, read answer one cycle later
// Notes: Address and data turn to their inverse once released
`default_nettype none

module sensor_host_model
    import temp_sensor_pkg::*;
(
    // Clock
    input wire logic clk,
    // Register port
    output logic [2:0] reg_addr,
    output logic reg_wr,
    output logic [15:0] reg_wdata,
    output logic reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic reg_rvalid
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] temp_msb;
    logic [7:0] temp_lsb;
    initial begin
        reg_addr = 3'h0;
        reg_wr = 1'b0;
        reg_wdata = 16'h0000;
        reg_rd = 1'b0;
    end
    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge clk);
        #1;
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge clk);
        #1;
        reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask : wr
    task automatic rd(input logic [2:0] a, output logic [15:0] d, output logic ok);
        @(posedge clk);
        #1;
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge clk);
        #1;
        reg_rd = 1'b0;
        reg_addr = ~a;
        ok = reg_rvalid;
        d = reg_rdata;
        if (a == ADDR_TEMP) begin
            temp_msb = d[15:8];
            temp_lsb = d[7:0];
        end
    endtask : rd
    // Coarse host keeps only whole degrees
    function automatic logic [8:0] nine_bit();
        return {temp_msb, temp_lsb[7]};
    endfunction : nine_bit
endmodule : sensor_host_model

`default_nettype wire

// file: testbench/temp_sensor_regs_test.sv
// Purpose: Self-checking bench for temp_sensor_regs
// Assumes: Default limits 147, 64 and 10 degrees, margin 5
// Notes: Identity codes are arbitrary
`default_nettype none
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin mismatches++; \
    $display("wrong value %s: expected %h, seen %h", n, e, g); end end

module temp_sensor_regs_test;
    timeunit 1ns;
    timeprecision 100ps;
    import temp_sensor_pkg::*;
    localparam logic [4:0] MAKER = 5'h15; // Arbitrary value
    localparam logic [2:0] REV = 3'h6; // Arbitrary value
    logic clk = 1'b0, sys_rst = 1'b1, conv_valid = 1'b0, reg_wr, reg_rd, reg_rvalid, result_ready_n, ok;
    logic [15:0] conv_code = 16'h0000, reg_wdata, reg_rdata, temp_q7, d;
    logic [2:0] reg_addr;
    logic [2:0] alarm_state;
    logic [7:0] setup_word;
    int mismatches = 0, n_tests = 0;
    logic [15:0] dflt [8] = '{16'h0080, 16'h0000, 16'h0000, {8'h00, MAKER, REV}, 16'h4980, 16'h0005,
        16'h2000, 16'h0500};
    // Code, temperature view, condition after temperature read
    logic [15:0] rows [8][3] = '{'{16'h0c87, 16'h0c80, 16'h0080}, '{16'h2300, 16'h2302, 16'h00a0},
        '{16'h1e00, 16'h1e02, 16'h0080}, '{16'h1d00, 16'h1d00, 16'h0080}, '{16'h4b00, 16'h4b06, 16'h00e0},
        '{16'hf600, 16'hf601, 16'h0090}, '{16'h0600, 16'h0601, 16'h0080}, '{16'h0800, 16'h0800, 16'h0080}};
    always #2.5 clk = ~clk;
    temp_sensor_regs #(.MAKER_CODE(MAKER), .REVISION_CODE(REV)) temp_sensor_regs_i (.clk, .sys_rst,
        .conv_valid, .conv_code, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata, .reg_rvalid,
        .setup_word, .alarm_state, .temp_q7, .result_ready_n);
    sensor_host_model sensor_host_model_i (.clk, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata,
        .reg_rvalid);
    ////////////////////////////////////////////////////////////////////////////////
    task automatic do_reset();
        sys_rst = 1'b1;
        repeat (6) @(posedge clk);
        #1 sys_rst = 1'b0;
    endtask : do_reset
    task automatic rchk(input string n, input logic [2:0] a, input logic [15:0] e);
        sensor_host_model_i.rd(a, d, ok);
        `CHK("rvalid", 1'b1, ok)
        `CHK(n, e, d)
    endtask : rchk
    // Waits past the flag update so a following read sees it
    task automatic conv(input logic [15:0] c);
        @(posedge clk);
        #1 conv_valid = 1'b1;
        conv_code = c;
        @(posedge clk);
        #1 conv_valid = 1'b0;
        conv_code = ~c;
        @(posedge clk);
        #1;
    endtask : conv
    task automatic end_sim();
        $display("comparisons %0d, mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : end_sim
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #50us;
        mismatches++;
        end_sim();
    end
    initial begin
        do_reset();
        for (int i = 0; i < 8; i++) rchk("reset value", 3'(i), dflt[i]);
        for (int i = 0; i < 8; i++) sensor_host_model_i.wr(3'(i), 16'hc3a5 ^ 16'(i));
        for (int i = 0; i < 8; i++) begin
            d = 16'hc3a5 ^ 16'(i);
            rchk("after write", 3'(i), i inside {1, 5} ? {8'h00, d[7:0]} : i inside {4, 6, 7} ? d : dflt[i]);
        end
        $display("test register map done");
        do_reset();
        conv(16'h0c87);
        rchk("ready low", ADDR_CONDITION, 16'h0000);
        for (int i = 0; i < 8; i++) begin
            if (i > 0) conv(rows[i][0]);
            `CHK("temp_q7", rows[i][0] & MASK_13BIT, temp_q7)
            rchk("temperature", ADDR_TEMP, rows[i][1]);
            rchk("condition", ADDR_CONDITION, rows[i][2]);
            rchk("condition again", ADDR_CONDITION, 16'h0080);
        end
        `CHK("nine bit", 9'h010, sensor_host_model_i.nine_bit())
        conv(16'h4b00);
        `CHK("alarm_state", 3'h6, alarm_state)
        conv(16'h0c80);
        rchk("recovered", ADDR_CONDITION, 16'h0000);
        $display("test alarms done");
        sensor_host_model_i.wr(ADDR_SETUP, 16'h0080);
        `CHK("setup_word", 8'h80, setup_word)
        conv(16'hf603);
        rchk("wide temperature", ADDR_TEMP, 16'hf603);
        `CHK("wide temp_q7", 16'hf603, temp_q7)
        for (int m = 0; m < 4; m++) begin
            conv(16'h0c80);
            sensor_host_model_i.wr(ADDR_SETUP, {9'h000, 2'(m), 5'h00});
            rchk("mode write", ADDR_CONDITION, (m == 1 || m == 2) ? 16'h0080 : 16'h0000);
        end
        $display("test modes done");
        end_sim();
    end
endmodule : temp_sensor_regs_test

`default_nettype wire
